// File: common/sbtfp_pkg.sv
// Operation
// - Fast PWM period is fixed 8/9/10 bit or set by capture or compare A.
// - Modes 5, 6, 7 count up to 0x00FF, 0x01FF, 0x03FF.
// - Mode 14 tops at capture register, mode 15 at compare A; then clear.
// - Overflow flag sets each time the counter reaches TOP in fast PWM.
// - Capture or compare A flag sets with overflow when it defines TOP.
// - Counter equal to a compare value sets that channel's match flag.
// - A compare value above TOP matches only while the counter runs above TOP.
// - Fixed-TOP modes mask compare writes above the resolution to zero.
// - Capture TOP is unbuffered; a low write makes the counter wrap first.
// - Compare A is double buffered, writes do not act at once.
// - Nonzero output mode routes the waveform to the pin, except a PWM mode 01 that does not toggle; direction gates driver.
// - Non-PWM output modes: none, toggle, clear, set on match.
// - Fast PWM mode 01 toggles channel A only in modes 14 and 15.
// - Fast PWM mode 10 clears on match, sets at TOP; 11 the reverse.
// - Compare equal to TOP with upper mode bit: match ignored, TOP action kept.
// - Capture pin is disconnected while the capture register is TOP.
// - Clock select: stop, divide 1/8/64/256/1024, external falling, rising.
// - External edges count even when the pin is an output.
// - Force strobes in non-PWM modes cause an immediate match, nothing stored.
package sbtfp_pkg;
   localparam logic [3:0] SBTFP_ADDR_CTRL_A = 4'h0;
   localparam logic [3:0] SBTFP_ADDR_CTRL_B = 4'h1;
   localparam logic [3:0] SBTFP_ADDR_CTRL_C = 4'h2;
   localparam logic [3:0] SBTFP_ADDR_COUNT = 4'h3;
   localparam logic [3:0] SBTFP_ADDR_CMP_A = 4'h4;
   localparam logic [3:0] SBTFP_ADDR_CMP_B = 4'h5;
   localparam logic [3:0] SBTFP_ADDR_CAPTURE = 4'h6;
   localparam logic [3:0] SBTFP_ADDR_FLAGS = 4'h7;
   localparam logic [3:0] SBTFP_ADDR_PINS = 4'h8;
   localparam logic [7:0] SBTFP_CTRL_A_RESET = 8'h00;
   localparam logic [7:0] SBTFP_CTRL_B_RESET = 8'h00;
   localparam logic [7:0] SBTFP_CTRL_A_MASK = 8'hF3;
   localparam logic [7:0] SBTFP_CTRL_B_MASK = 8'h1F;
   localparam int SBTFP_MODE_A_HI = 7;
   localparam int SBTFP_MODE_B_HI = 5;
   localparam int SBTFP_FORCE_A_BIT = 7;
   localparam int SBTFP_FORCE_B_BIT = 6;
   localparam int SBTFP_FLAG_OVF_BIT = 0;
   localparam int SBTFP_FLAG_MA_BIT = 1;
   localparam int SBTFP_FLAG_MB_BIT = 2;
   localparam int SBTFP_FLAG_CAP_BIT = 5;
   localparam logic [3:0] SBTFP_WGM_FAST8 = 4'h5;
   localparam logic [3:0] SBTFP_WGM_FAST9 = 4'h6;
   localparam logic [3:0] SBTFP_WGM_FAST10 = 4'h7;
   localparam logic [3:0] SBTFP_WGM_FAST_CAP = 4'hE;
   localparam logic [3:0] SBTFP_WGM_FAST_CMPA = 4'hF;
   localparam logic [3:0] SBTFP_WGM_CTC_CMPA = 4'h4;
   localparam logic [3:0] SBTFP_WGM_CTC_CAP = 4'hC;
   localparam logic [15:0] SBTFP_TOP8 = 16'h00FF;
   localparam logic [15:0] SBTFP_TOP9 = 16'h01FF;
   localparam logic [15:0] SBTFP_TOP10 = 16'h03FF;
   localparam logic [15:0] SBTFP_MAX = 16'hFFFF;
   localparam logic [9:0] SBTFP_DIV8 = 10'h007;
   localparam logic [9:0] SBTFP_DIV64 = 10'h03F;
   localparam logic [9:0] SBTFP_DIV256 = 10'h0FF;
   localparam logic [9:0] SBTFP_DIV1024 = 10'h3FF;
   typedef struct packed {
      logic [1:0] mode_a;
      logic [1:0] mode_b;
      logic [3:0] wgm;
      logic [2:0] cs;
   } sbtfp_cfg_t;
endpackage

// File: rtl/sbtfp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sbtfp_timer
   import sbtfp_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_count_pin,
   input wire logic capture_input_pin,
   input wire logic port_out_a,
   input wire logic port_out_b,
   input wire logic dir_out_a,
   input wire logic dir_out_b,
   output logic waveform_out_a,
   output logic waveform_out_a_oe,
   output logic waveform_out_b,
   output logic waveform_out_b_oe,
   output logic capture_input_enable,
   output logic [7:0] flags_out
);
   // ==========================================================
   // Register bus
   // ==========================================================
   logic ack_reg;
   logic [7:0] ctrl_a_reg;
   logic [7:0] ctrl_b_reg;
   logic [15:0] count_reg;
   logic [15:0] cmp_a_reg;
   logic [15:0] cmp_b_reg;
   logic [15:0] cmp_a_buf_reg;
   logic [15:0] cmp_b_buf_reg;
   logic [15:0] capture_reg;
   logic [7:0] flags_reg;
   logic [31:0] rdata_reg;
   logic wave_a_reg;
   logic wave_b_reg;
   logic [2:0] ext_sync_reg;
   logic [9:0] prescale_reg;
   logic [2:0] cap_sync_reg;
   logic [15:0] cap_latch_reg;
   sbtfp_cfg_t cfg;
   logic acc;
   logic wr;
   logic [15:0] wdata16;
   logic [3:0] wgm;
   logic pwm_mode;
   logic fixed_top;
   logic [15:0] top;
   logic [15:0] res_mask;
   logic tick;
   logic at_top;
   logic match_a;
   logic match_b;
   logic force_a;
   logic force_b;
   logic ctc_clear;
   logic cap_edge;
   logic ext_level_reg;
   logic cap_level_reg;
   logic ext_settled;
   logic cap_settled;
   logic pwm_toggle_ok;

   assign acc = avs_read | avs_write;
   // One wait state: the access completes on the second edge after the request.
   assign avs_waitrequest = acc & ~ack_reg;
   assign wr = avs_write & ack_reg;
   assign wdata16 = avs_writedata[15:0];

   always_ff @(posedge clock) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= acc & ~ack_reg;
      end
   end

   assign cfg.mode_a = ctrl_a_reg[7:6];
   assign cfg.mode_b = ctrl_a_reg[5:4];
   assign cfg.wgm = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
   assign cfg.cs = ctrl_b_reg[2:0];
   assign wgm = cfg.wgm;

   // ==========================================================
   // Mode decode and TOP selection
   // ==========================================================
   assign pwm_mode = (wgm != 4'h0) && (wgm != SBTFP_WGM_CTC_CMPA) && (wgm != SBTFP_WGM_CTC_CAP);
   assign fixed_top = (wgm[1:0] != 2'b00) && (wgm[3:2] == 2'b00 || wgm[3:2] == 2'b01);
   // Only the register-defined fast PWM modes may toggle channel A.
   assign pwm_toggle_ok = (wgm == SBTFP_WGM_FAST_CAP) || (wgm == SBTFP_WGM_FAST_CMPA);

   always_comb begin
      case (wgm[1:0])
         2'b01: res_mask = SBTFP_TOP8;
         2'b10: res_mask = SBTFP_TOP9;
         2'b11: res_mask = SBTFP_TOP10;
         default: res_mask = SBTFP_MAX;
      endcase
   end

   always_comb begin
      if (fixed_top) begin
         top = res_mask;
      end else if (wgm == SBTFP_WGM_FAST_CAP || wgm == SBTFP_WGM_CTC_CAP) begin
         top = capture_reg;
      end else if (wgm == SBTFP_WGM_FAST_CMPA || wgm == SBTFP_WGM_CTC_CMPA) begin
         top = cmp_a_reg;
      end else begin
         top = SBTFP_MAX;
      end
   end

   assign capture_input_enable = ~(wgm == SBTFP_WGM_FAST_CAP || wgm == SBTFP_WGM_CTC_CAP);

   // ==========================================================
   // Clock source and prescaler
   // ==========================================================
   // External pin is sampled regardless of its port direction.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ext_sync_reg <= 3'b000;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], external_count_pin};
      end
   end

   // A pin change counts only once the second and third stages agree.
   assign ext_settled = (ext_sync_reg[2] == ext_sync_reg[1]);

   always_ff @(posedge clock) begin
      if (!resetn) begin
         ext_level_reg <= 1'b0;
      end else if (ext_settled) begin
         ext_level_reg <= ext_sync_reg[2];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         prescale_reg <= 10'h000;
      end else begin
         prescale_reg <= prescale_reg + 10'h001;
      end
   end

   always_comb begin
      case (cfg.cs)
         3'b001: tick = 1'b1;
         3'b010: tick = (prescale_reg[2:0] == SBTFP_DIV8[2:0]);
         3'b011: tick = (prescale_reg[5:0] == SBTFP_DIV64[5:0]);
         3'b100: tick = (prescale_reg[7:0] == SBTFP_DIV256[7:0]);
         3'b101: tick = (prescale_reg == SBTFP_DIV1024);
         3'b110: tick = ext_settled & ext_level_reg & ~ext_sync_reg[2];
         3'b111: tick = ext_settled & ~ext_level_reg & ext_sync_reg[2];
         default: tick = 1'b0;
      endcase
   end

   // ==========================================================
   // Counter and compare
   // ==========================================================
   assign at_top = (count_reg == top);
   // A compare value above TOP is reached, and matches, only once the counter is written or left above TOP.
   assign match_a = tick && (count_reg == cmp_a_reg) &&
      !(pwm_mode && cmp_a_reg == top && cfg.mode_a[1]);
   assign match_b = tick && (count_reg == cmp_b_reg) &&
      !(pwm_mode && cmp_b_reg == top && cfg.mode_b[1]);
   assign ctc_clear = !pwm_mode && (wgm != 4'h0);
   assign force_a = wr && avs_address == SBTFP_ADDR_CTRL_C && !pwm_mode &&
      avs_writedata[SBTFP_FORCE_A_BIT];
   assign force_b = wr && avs_address == SBTFP_ADDR_CTRL_C && !pwm_mode &&
      avs_writedata[SBTFP_FORCE_B_BIT];

   always_ff @(posedge clock) begin
      if (!resetn) begin
         count_reg <= 16'h0000;
      end else if (wr && avs_address == SBTFP_ADDR_COUNT) begin
         count_reg <= wdata16;
      end else if (tick) begin
         if ((pwm_mode || ctc_clear) && at_top) begin
            count_reg <= 16'h0000;
         end else begin
            count_reg <= count_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctrl_a_reg <= SBTFP_CTRL_A_RESET;
         ctrl_b_reg <= SBTFP_CTRL_B_RESET;
         capture_reg <= 16'h0000;
      end else if (wr) begin
         if (avs_address == SBTFP_ADDR_CTRL_A) begin
            ctrl_a_reg <= avs_writedata[7:0] & SBTFP_CTRL_A_MASK;
         end
         if (avs_address == SBTFP_ADDR_CTRL_B) begin
            ctrl_b_reg <= avs_writedata[7:0] & SBTFP_CTRL_B_MASK;
         end
         if (avs_address == SBTFP_ADDR_CAPTURE) begin
            capture_reg <= wdata16;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cmp_a_buf_reg <= 16'h0000;
         cmp_b_buf_reg <= 16'h0000;
      end else if (wr) begin
         if (avs_address == SBTFP_ADDR_CMP_A) begin
            cmp_a_buf_reg <= fixed_top ? (wdata16 & res_mask) : wdata16;
         end
         if (avs_address == SBTFP_ADDR_CMP_B) begin
            cmp_b_buf_reg <= fixed_top ? (wdata16 & res_mask) : wdata16;
         end
      end
   end

   // Outside PWM the buffers are transparent; in PWM they load at TOP.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cmp_a_reg <= 16'h0000;
         cmp_b_reg <= 16'h0000;
      end else if (!pwm_mode || (tick && at_top)) begin
         cmp_a_reg <= cmp_a_buf_reg;
         cmp_b_reg <= cmp_b_buf_reg;
      end
   end

   // ==========================================================
   // Capture input
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cap_sync_reg <= 3'b000;
      end else begin
         cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin};
      end
   end

   assign cap_settled = (cap_sync_reg[2] == cap_sync_reg[1]);

   // The level is tracked while the pin is disconnected, so enabling it makes no false edge.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cap_level_reg <= 1'b0;
      end else if (cap_settled) begin
         cap_level_reg <= cap_sync_reg[2];
      end
   end

   assign cap_edge = capture_input_enable && cap_settled && ~cap_level_reg &&
      cap_sync_reg[2];

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cap_latch_reg <= 16'h0000;
      end else if (cap_edge) begin
         cap_latch_reg <= count_reg;
      end
   end

   // ==========================================================
   // Flags: set wins over a write-one-to-clear
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!resetn) begin
         flags_reg <= 8'h00;
      end else begin
         if (wr && avs_address == SBTFP_ADDR_FLAGS) begin
            flags_reg <= flags_reg & ~avs_writedata[7:0];
         end
         if (tick && (pwm_mode ? at_top : count_reg == SBTFP_MAX)) begin
            flags_reg[SBTFP_FLAG_OVF_BIT] <= 1'b1;
         end
         if (match_a || (tick && at_top && wgm == SBTFP_WGM_FAST_CMPA)) begin
            flags_reg[SBTFP_FLAG_MA_BIT] <= 1'b1;
         end
         if (match_b) begin
            flags_reg[SBTFP_FLAG_MB_BIT] <= 1'b1;
         end
         if (cap_edge || (tick && at_top && wgm == SBTFP_WGM_FAST_CAP)) begin
            flags_reg[SBTFP_FLAG_CAP_BIT] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Waveform generation
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wave_a_reg <= 1'b0;
      end else if (pwm_mode) begin
         if (cfg.mode_a == 2'b01) begin
            if (match_a && pwm_toggle_ok) begin
               wave_a_reg <= ~wave_a_reg;
            end
         end else if (cfg.mode_a[1]) begin
            if (tick && at_top) begin
               wave_a_reg <= ~cfg.mode_a[0];
            end else if (match_a) begin
               wave_a_reg <= cfg.mode_a[0];
            end
         end
      end else if (match_a || force_a) begin
         case (cfg.mode_a)
            2'b01: wave_a_reg <= ~wave_a_reg;
            2'b10: wave_a_reg <= 1'b0;
            2'b11: wave_a_reg <= 1'b1;
            default: wave_a_reg <= wave_a_reg;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         wave_b_reg <= 1'b0;
      end else if (pwm_mode) begin
         if (cfg.mode_b[1]) begin
            if (tick && at_top) begin
               wave_b_reg <= ~cfg.mode_b[0];
            end else if (match_b) begin
               wave_b_reg <= cfg.mode_b[0];
            end
         end
      end else if (match_b || force_b) begin
         case (cfg.mode_b)
            2'b01: wave_b_reg <= ~wave_b_reg;
            2'b10: wave_b_reg <= 1'b0;
            2'b11: wave_b_reg <= 1'b1;
            default: wave_b_reg <= wave_b_reg;
         endcase
      end
   end

   // Channel B in PWM with mode 01 stays on the port function.
   // In other fast PWM modes, mode 01 leaves channel A on the port function.
   assign waveform_out_a = ((cfg.mode_a != 2'b00) && !(pwm_mode && cfg.mode_a == 2'b01 &&
      !pwm_toggle_ok)) ? wave_a_reg : port_out_a;
   assign waveform_out_b = ((cfg.mode_b != 2'b00) && !(pwm_mode && cfg.mode_b == 2'b01)) ?
      wave_b_reg : port_out_b;
   assign waveform_out_a_oe = dir_out_a;
   assign waveform_out_b_oe = dir_out_b;
   assign flags_out = flags_reg;

   // ==========================================================
   // Read data
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_reg <= 32'h00000000;
      end else if (avs_read && !ack_reg) begin
         case (avs_address)
            SBTFP_ADDR_CTRL_A: rdata_reg <= {24'h000000, ctrl_a_reg};
            SBTFP_ADDR_CTRL_B: rdata_reg <= {24'h000000, ctrl_b_reg};
            SBTFP_ADDR_COUNT: rdata_reg <= {16'h0000, count_reg};
            SBTFP_ADDR_CMP_A: rdata_reg <= {16'h0000, cmp_a_buf_reg};
            SBTFP_ADDR_CMP_B: rdata_reg <= {16'h0000, cmp_b_buf_reg};
            SBTFP_ADDR_CAPTURE: rdata_reg <= {16'h0000, capture_enable_value(capture_reg,
               cap_latch_reg, capture_input_enable)};
            SBTFP_ADDR_FLAGS: rdata_reg <= {24'h000000, flags_reg};
            SBTFP_ADDR_PINS: rdata_reg <= {30'h00000000, wave_b_reg, wave_a_reg};
            default: rdata_reg <= 32'h00000000;
         endcase
      end
   end
   assign avs_readdata = rdata_reg;

   function automatic logic [15:0] capture_enable_value(input logic [15:0] top_v,
      input logic [15:0] cap_v, input logic cap_en);
      capture_enable_value = cap_en ? cap_v : top_v;
   endfunction
endmodule
`default_nettype wire

// File: bench/sbtfp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sbtfp_chk
   import sbtfp_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic port_out_a,
   input wire logic port_out_b,
   input wire logic dir_out_a,
   input wire logic dir_out_b,
   input wire logic waveform_out_b_oe,
   input wire logic waveform_out_a,
   input wire logic waveform_out_a_oe,
   input wire logic waveform_out_b,
   input wire logic capture_input_enable,
   input wire logic [7:0] flags_out
);
   // ==========
   // Shadow of the output modes and waveform mode, taken from completed writes.
   logic [1:0] mode_a;
   logic [1:0] mode_b;
   logic [3:0] wgm;
   logic take;
   assign take = avs_write && !avs_waitrequest;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         mode_a <= 2'h0;
         mode_b <= 2'h0;
         wgm <= 4'h0;
      end else if (take && avs_address == SBTFP_ADDR_CTRL_A) begin
         mode_a <= avs_writedata[7:6];
         mode_b <= avs_writedata[5:4];
         wgm[1:0] <= avs_writedata[1:0];
      end else if (take && avs_address == SBTFP_ADDR_CTRL_B) begin
         wgm[3:2] <= avs_writedata[4:3];
      end
   end
   // ==========
   // Properties.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   sequence s_start;
      $rose(avs_read || avs_write);
   endsequence
   sequence s_held;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   property p_first_wait;
      s_start |-> avs_waitrequest;
   endproperty
   property p_one_wait;
      s_held |=> !avs_waitrequest;
   endproperty
   property p_oe_a;
      waveform_out_a_oe == dir_out_a;
   endproperty
   property p_oe_b;
      waveform_out_b_oe == dir_out_b;
   endproperty
   property p_pwm_port_a;
      wgm == SBTFP_WGM_FAST8 && mode_a == 2'h1 |-> waveform_out_a == port_out_a;
   endproperty
   property p_port_a;
      mode_a == 2'h0 |-> waveform_out_a == port_out_a;
   endproperty
   property p_port_b;
      mode_b == 2'h0 |-> waveform_out_b == port_out_b;
   endproperty
   property p_cap_off;
      wgm == SBTFP_WGM_FAST_CAP |-> !capture_input_enable;
   endproperty
   property p_cap_on;
      wgm == SBTFP_WGM_FAST8 |-> capture_input_enable;
   endproperty
   property p_top_a;
      wgm == SBTFP_WGM_FAST_CMPA && $rose(flags_out[0]) |-> flags_out[1];
   endproperty
   property p_top_cap;
      wgm == SBTFP_WGM_FAST_CAP && $rose(flags_out[0]) |-> flags_out[5];
   endproperty
   property p_reset;
      disable iff (1'h0) $rose(resetn) |-> flags_out == 8'h00;
   endproperty
   a_first_wait: assert property (p_first_wait) else $error("no wait state");
   a_one_wait: assert property (p_one_wait) else $error("wait state too long");
   a_oe_a: assert property (p_oe_a) else $error("enable a wrong");
   a_oe_b: assert property (p_oe_b) else $error("enable b wrong");
   a_pwm_port_a: assert property (p_pwm_port_a) else $error("pin a not port in pwm");
   a_port_a: assert property (p_port_a) else $error("pin a not port");
   a_port_b: assert property (p_port_b) else $error("pin b not port");
   a_cap_off: assert property (p_cap_off) else $error("capture pin on");
   a_cap_on: assert property (p_cap_on) else $error("capture pin off");
   a_top_a: assert property (p_top_a) else $error("match a missing at top");
   a_top_cap: assert property (p_top_cap) else $error("capture flag missing");
   a_reset: assert property (p_reset) else $error("flags not cleared");
endmodule
bind sbtfp_timer sbtfp_chk u_sbtfp_chk (.clock, .resetn, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_waitrequest, .port_out_a, .port_out_b, .dir_out_a, .waveform_out_a,
   .waveform_out_a_oe, .waveform_out_b, .capture_input_enable, .flags_out, .dir_out_b,
   .waveform_out_b_oe);
`default_nettype wire

// File: bench/sbtfp_pins.sv
`timescale 1ns/1ps
`default_nettype none
module sbtfp_pins (
   input wire logic clock,
   output logic external_count_pin,
   output logic capture_input_pin
);
   // ==========
   // Pulses each hold a level long enough to pass the input synchroniser.
   initial begin
      external_count_pin = 1'h0;
      capture_input_pin = 1'h0;
   end
   task automatic pulse(input int n);
      repeat (n) begin
         repeat (4) @(posedge clock);
         external_count_pin <= 1'h1;
         repeat (4) @(posedge clock);
         external_count_pin <= 1'h0;
      end
      repeat (6) @(posedge clock);
   endtask
   task automatic strobe_capture();
      capture_input_pin <= 1'h1;
      repeat (4) @(posedge clock);
      capture_input_pin <= 1'h0;
      repeat (6) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// File: bench/sixteen_bit_timer_fast_pwm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_fast_pwm_tb;
   import sbtfp_pkg::*;
   logic clock, resetn, avs_read, avs_write, port_out_a, port_out_b, dir_out_a, dir_out_b;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic avs_waitrequest, waveform_out_a, waveform_out_a_oe, waveform_out_b, waveform_out_b_oe;
   logic external_count_pin, capture_input_pin, capture_input_enable;
   logic [7:0] flags_out;
   int err_count = 0, n_compared = 0, ha, hb, t0, cyc = 0;
   int divs[5] = '{1, 8, 64, 256, 1024};
   logic [15:0] tops[3] = '{SBTFP_TOP8, SBTFP_TOP9, SBTFP_TOP10};
   logic [1:0] mbs[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
   logic [15:0] cbs[5] = '{16'h8, 16'h8, 16'h8, 16'h8, 16'h10};
   int ebs[5] = '{170, 170, 90, 80, 170};
   logic [1:0] fms[4] = '{2'h2, 2'h3, 2'h1, 2'h1};
   logic fes[4] = '{1'h0, 1'h1, 1'h0, 1'h1};
   sbtfp_timer u_sbtfp_timer (.clock, .resetn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .external_count_pin,
      .capture_input_pin, .port_out_a, .port_out_b, .dir_out_a, .dir_out_b, .waveform_out_a,
      .waveform_out_a_oe, .waveform_out_b, .waveform_out_b_oe, .capture_input_enable, .flags_out);
   sbtfp_pins u_sbtfp_pins (.clock, .external_count_pin, .capture_input_pin);
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;
   // ==========
   // Checking and bus tasks.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] near(logic [31:0] v, int e);
      return {31'h0, (v + 3 >= e && v <= e + 3)};
   endfunction
   task automatic conclude();
      if (err_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      avs_read <= r;
      avs_write <= !r;
      avs_address <= a;
      avs_writedata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (avs_waitrequest === 1'h0) break;
      end
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (i == 20) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      bus(1'h0, a, d);
   endtask
   task automatic rc(logic [3:0] a, logic [31:0] e, string what);
      bus(1'h1, a, 32'h0);
      chk(q, e, what);
   endtask
   task automatic ctl(logic [1:0] ma, logic [1:0] mb, logic [3:0] w, logic [2:0] cs);
      wr(SBTFP_ADDR_CTRL_A, {24'h0, ma, mb, 2'h0, w[1:0]});
      wr(SBTFP_ADDR_CTRL_B, {27'h0, w[3:2], cs});
   endtask
   task automatic halt();
      ctl(2'h0, 2'h0, 4'h0, 3'h0);
      wr(SBTFP_ADDR_COUNT, 32'h0);
   endtask
   task automatic duty();
      ha = 0;
      hb = 0;
      repeat (170) begin
         @(posedge clock);
         ha += (waveform_out_a === 1'h1);
         hb += (waveform_out_b === 1'h1);
      end
   endtask
   // ==========
   // Main sequence.
   initial begin
      resetn = 1'h0;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      port_out_a = 1'h0;
      port_out_b = 1'h1;
      dir_out_a = 1'h1;
      dir_out_b = 1'h0;
      repeat (6) @(posedge clock);
      resetn <= 1'h1;
      rc(SBTFP_ADDR_CTRL_A, 32'h0, "ctrl a reset");
      rc(SBTFP_ADDR_CTRL_B, 32'h0, "ctrl b reset");
      rc(4'h9, 32'h0, "unmapped");
      wr(SBTFP_ADDR_CTRL_A, 32'hFF);
      rc(SBTFP_ADDR_CTRL_A, 32'hF3, "ctrl a bits");
      wr(SBTFP_ADDR_CTRL_A, 32'h0);
      repeat (20) @(posedge clock);
      rc(SBTFP_ADDR_COUNT, 32'h0, "stopped");
      foreach (divs[k]) begin
         halt();
         ctl(2'h0, 2'h0, 4'h0, 3'(k + 1));
         t0 = cyc;
         repeat (8 * divs[k]) @(posedge clock);
         bus(1'h1, SBTFP_ADDR_COUNT, 32'h0);
         chk(near(q, (cyc - t0) / divs[k]), 32'h1, "prescale");
      end
      halt();
      ctl(2'h0, 2'h0, 4'h0, 3'h7);
      u_sbtfp_pins.pulse(5);
      rc(SBTFP_ADDR_COUNT, 32'h5, "ext rising");
      halt();
      ctl(2'h0, 2'h0, 4'h0, 3'h6);
      u_sbtfp_pins.pulse(3);
      rc(SBTFP_ADDR_COUNT, 32'h3, "ext falling");
      port_out_a <= 1'h1;
      foreach (tops[k]) begin
         halt();
         ctl(2'h0, 2'h0, 4'(5 + k), 3'h0);
         wr(SBTFP_ADDR_CMP_A, 32'h1234);
         rc(SBTFP_ADDR_CMP_A, {16'h0, 16'h1234 & tops[k]}, "cmp mask");
         wr(SBTFP_ADDR_COUNT, {16'h0, tops[k] - 16'h1});
         wr(SBTFP_ADDR_FLAGS, 32'hFF);
         ctl(2'h1, 2'h0, 4'(5 + k), 3'h1);
         repeat (8) @(posedge clock);
         bus(1'h1, SBTFP_ADDR_COUNT, 32'h0);
         chk(near(q, 9), 32'h1, "wrap at top");
         bus(1'h1, SBTFP_ADDR_FLAGS, 32'h0);
         chk(q & 32'h5, 32'h5, "flags at top");
         chk(32'(waveform_out_a), 32'h1, "pin a port in pwm");
      end
      // Compare B is put above TOP on purpose, so it must never match.
      halt();
      wr(SBTFP_ADDR_CMP_A, 32'h10);
      wr(SBTFP_ADDR_CMP_B, 32'h30);
      ctl(2'h1, 2'h0, SBTFP_WGM_FAST_CMPA, 3'h1);
      wr(SBTFP_ADDR_FLAGS, 32'hFF);
      repeat (100) @(posedge clock);
      rc(SBTFP_ADDR_FLAGS, 32'h3, "top a flags");
      foreach (mbs[k]) begin
         ctl(2'h1, mbs[k], SBTFP_WGM_FAST_CMPA, 3'h1);
         wr(SBTFP_ADDR_CMP_B, {16'h0, cbs[k]});
         repeat (40) @(posedge clock);
         duty();
         chk(near(ha, 85), 32'h1, "duty a");
         chk(near(hb, ebs[k]), 32'h1, "duty b");
      end
      halt();
      dir_out_a <= 1'h0;
      dir_out_b <= 1'h1;
      @(posedge clock);
      chk(32'({waveform_out_a_oe, waveform_out_b_oe}), 32'h1, "pin enables");
      foreach (fms[k]) begin
         ctl(fms[k], fms[k], 4'h0, 3'h0);
         wr(SBTFP_ADDR_CTRL_C, 32'hC0);
         repeat (2) @(posedge clock);
         q = 32'({waveform_out_b, waveform_out_a});
         chk(q, 32'({fes[k], fes[k]}), "force");
      end
      rc(SBTFP_ADDR_CTRL_C, 32'h0, "ctrl c");
      halt();
      ctl(2'h0, 2'h0, SBTFP_WGM_FAST_CAP, 3'h0);
      wr(SBTFP_ADDR_CAPTURE, 32'h40);
      ctl(2'h0, 2'h0, SBTFP_WGM_FAST_CAP, 3'h1);
      wr(SBTFP_ADDR_FLAGS, 32'hFF);
      repeat (100) @(posedge clock);
      rc(SBTFP_ADDR_FLAGS, 32'h27, "top cap flags");
      wr(SBTFP_ADDR_COUNT, 32'h200);
      wr(SBTFP_ADDR_CAPTURE, 32'h20);
      bus(1'h1, SBTFP_ADDR_COUNT, 32'h0);
      chk({31'h0, q > 32'h100}, 32'h1, "no early wrap");
      u_sbtfp_pins.strobe_capture();
      rc(SBTFP_ADDR_CAPTURE, 32'h20, "capture pin off");
      conclude();
   end
endmodule
`default_nettype wire
